// File: hcl_pkg.sv
package hcl_pkg;
	// Clock and serial timing.
	localparam int CLK_HZ = 100_000_000;
	localparam int I2C_BPS = 100_000;
	localparam int QTR_CYC = CLK_HZ / I2C_BPS / 4;
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
	localparam int OPWAIT_US = 500;
	localparam int OPWAIT_CYC = OPWAIT_US * (CLK_HZ / 1_000_000);
	localparam int TMO_MS = 25;
	localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);
	localparam int OPW_W = 16;
	localparam int TMO_W = 22;
	localparam logic [OPW_W-1:0] STRAP_AT = 16'h0004;
	// Bus addresses and register map.
	localparam logic [6:0] EE_ADDR = 7'h50;
	localparam logic [6:0] SMB_ADDR = 7'h2C;
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam logic [7:0] EE_FIRST = 8'h00;
	localparam logic [7:0] EE_LAST = 8'hFE;
	localparam logic [7:0] REG_LAST = 8'h3F;
	localparam logic [7:0] REG_STATUS = 8'hFF;
	localparam int ATTACH_BIT = 0;
	localparam logic [7:0] BLK_MAX = 8'h20;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] BIT_MSB = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_EDGE = 4'h1; // Bit count left by the clock rise that frames a START or STOP.
	// Source select codes, {hi, lo}.
	localparam logic [1:0] SRC_DEFAULT = 2'h0;
	localparam logic [1:0] SRC_SMBUS = 2'h2;
	localparam logic [6:0] PORT_ALL_ON = 7'h7F;
	// Master sequencer states.
	typedef enum logic [2:0] {
		M_WAIT = 3'b000, M_START = 3'b001, M_WBYTE = 3'b010, M_RBYTE = 3'b011,
		M_STOP = 3'b100, M_DONE = 3'b101, M_OFF = 3'b110
	} hcl_mst_t;
	// Slave protocol states.
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_CMD = 3'b010, S_CNT = 3'b011,
		S_WDATA = 3'b100, S_RDATA = 3'b101, S_COMMIT = 3'b110
	} hcl_slv_t;
	// Status outputs that travel together.
	typedef struct packed {
		logic usb_attach;
		logic cfg_done;
		logic load_error;
		logic led_enable;
		logic led_amber_act_low;
		logic led_green_act_low;
	} hcl_stat_t;
	// Whole core-domain state.
	typedef struct packed {
		logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, bit_s1, bit_s2, rise_dly;
		logic [1:0] sel_s1, sel_s2, led_s1, led_s2, src;
		logic [OPW_W-1:0] opcnt;
		hcl_mst_t mst;
		logic [1:0] ph, mseq;
		logic [7:0] qcnt, mbyte, maddr;
		logic [3:0] mbit;
		hcl_slv_t slv;
		logic [3:0] sbit;
		logic [7:0] sshift, txb, ptr, cptr;
		logic stx, sack, rd_ok;
		logic [5:0] bcnt, bidx;
		logic [TMO_W-1:0] tmo;
		logic [31:0][7:0] wbuf;
		logic [255:0][7:0] mem;
		logic scl_o, scl_oe, sda_o, sda_oe;
		logic [6:0] pwr;
		hcl_stat_t stat;
	} hcl_core_t;
endpackage : hcl_pkg

// File: hcl_loader.sv
module hcl_loader #(
	parameter int OPWAIT_CYCLES = hcl_pkg::OPWAIT_CYC, // Cycles from reset release to operation.
	parameter int TIMEOUT_CYCLES = hcl_pkg::TMO_CYC // Clock-low cycles before the slave aborts.
) (
	// Core clock and synchronous reset.
	input wire logic clk,
	input wire logic rst_n,
	// Serial clock pin used as the link clock.
	input wire logic scl_link_clk,
	// Source select straps.
	input wire logic config_source_select_hi,
	input wire logic config_source_select_lo,
	// Open-drain serial clock.
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Open-drain serial data.
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// LED strap pins.
	input wire logic led_amber_in,
	input wire logic led_green_in,
	// Hub-side results.
	output logic [6:0] port_power_enable,
	output hcl_pkg::hcl_stat_t status
);
	// Registered state and its next value.
	hcl_pkg::hcl_core_t q;
	hcl_pkg::hcl_core_t d;
	// Data bit caught on the link clock.
	logic lk_bit_q;
	// Counter widths, brought into scope for the size casts below.
	localparam int OPW_W = hcl_pkg::OPW_W;
	localparam int TMO_W = hcl_pkg::TMO_W;

	// Picks one bit of a byte, most significant first.
	function automatic logic bit_of(input logic [7:0] b, input logic [3:0] i);
		return b[3'(hcl_pkg::BIT_MSB - i)];
	endfunction : bit_of

	// True for addresses that hold a real register.
	function automatic logic reg_defined(input logic [7:0] a);
		return (a <= hcl_pkg::REG_LAST) || (a == hcl_pkg::REG_STATUS);
	endfunction : reg_defined

	// Link domain: the data bit is caught on each rising serial clock.
	// It is pure data, so it needs no reset; the core only reads it after a rise.
	always_ff @(posedge scl_link_clk) begin
		lk_bit_q <= sda_in;
	end

	// Next-state logic for the whole core domain.
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_ev;
		logic stop_ev;
		logic mtick;
		logic oper;
		logic smb_on;
		logic [7:0] rx;
		logic [7:0] waddr;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_ev = 1'b0;
		stop_ev = 1'b0;
		mtick = 1'b0;
		oper = 1'b0;
		smb_on = 1'b0;
		rx = hcl_pkg::ZERO_BYTE;
		waddr = hcl_pkg::ZERO_BYTE;
		d = q;

		// Pin synchronisers; only the second stage and later are looked at.
		d.scl_s1 = scl_in;
		d.scl_s2 = q.scl_s1;
		d.scl_s3 = q.scl_s2;
		d.sda_s1 = sda_in;
		d.sda_s2 = q.sda_s1;
		d.sda_s3 = q.sda_s2;
		d.bit_s1 = lk_bit_q;
		d.bit_s2 = q.bit_s1;
		d.sel_s1 = {config_source_select_hi, config_source_select_lo};
		d.sel_s2 = q.sel_s1;
		d.led_s1 = {led_amber_in, led_green_in};
		d.led_s2 = q.led_s1;

		// Bus events seen on synchronised levels.
		scl_rise = q.scl_s2 & ~q.scl_s3;
		scl_fall = ~q.scl_s2 & q.scl_s3;
		start_ev = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
		stop_ev = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
		// The captured bit is read one cycle after the rise to let its own sync settle.
		d.rise_dly = scl_rise;
		rx = {q.sshift[6:0], q.bit_s2};

		// Operational delay after reset release, with strap capture early in it.
		oper = (q.opcnt == OPW_W'(OPWAIT_CYCLES));
		if (!oper) begin
			d.opcnt = q.opcnt + 1'b1;
		end
		if (q.opcnt == hcl_pkg::STRAP_AT) begin
			d.src = q.sel_s2;
			d.stat.led_amber_act_low = q.led_s2[1];
			d.stat.led_green_act_low = q.led_s2[0];
		end
		smb_on = oper && (q.src == hcl_pkg::SRC_SMBUS);

		// Quarter-bit timer for the master.
		if (q.mst == hcl_pkg::M_WAIT || q.mst == hcl_pkg::M_DONE || q.mst == hcl_pkg::M_OFF) begin
			d.qcnt = '0;
		end else if (q.qcnt == hcl_pkg::QTR_LAST) begin
			mtick = 1'b1;
			d.qcnt = '0;
			d.ph = q.ph + 1'b1;
		end else begin
			d.qcnt = q.qcnt + 1'b1;
		end

		// EEPROM master: the pins only ever pull low, four phases per bit.
		case (q.mst)
			hcl_pkg::M_WAIT: begin
				if (oper) begin
					// Default and SMBus sources never touch the EEPROM.
					if (q.src == hcl_pkg::SRC_SMBUS || q.src == hcl_pkg::SRC_DEFAULT) begin
						d.mst = hcl_pkg::M_OFF;
					end else begin
						d.mst = hcl_pkg::M_START;
						d.ph = '0;
						d.mseq = '0;
					end
				end
			end
			hcl_pkg::M_START: begin
				// Clock low, data released, clock high, data low: a (repeated) START.
				d.scl_oe = (q.ph <= 2'h1);
				if (q.ph == 2'h1) begin
					d.sda_oe = 1'b0;
				end else if (q.ph == 2'h3) begin
					d.sda_oe = 1'b1;
				end
				if (mtick && q.ph == 2'h3) begin
					d.mst = hcl_pkg::M_WBYTE;
					d.mbit = '0;
					// Write address first, read address after the turnaround.
					d.mbyte = {hcl_pkg::EE_ADDR, q.mseq[1]};
				end
			end
			hcl_pkg::M_WBYTE, hcl_pkg::M_RBYTE: begin
				d.scl_oe = (q.ph <= 2'h1);
				// Data changes only in the second low phase, never near a clock edge.
				if (q.ph == 2'h1) begin
					if (q.mst == hcl_pkg::M_WBYTE) begin
						d.sda_oe = (q.mbit != hcl_pkg::BIT_ACK) && !bit_of(q.mbyte, q.mbit);
					end else begin
						d.sda_oe = (q.mbit == hcl_pkg::BIT_ACK) && (q.maddr != hcl_pkg::EE_LAST);
					end
				end
				// Sample in the middle of the high time.
				if (mtick && q.ph == 2'h2) begin
					if (q.mst == hcl_pkg::M_RBYTE && q.mbit != hcl_pkg::BIT_ACK) begin
						d.mbyte = {q.mbyte[6:0], q.sda_s2};
					end else if (q.mst == hcl_pkg::M_WBYTE && q.mbit == hcl_pkg::BIT_ACK && q.sda_s2) begin
						d.stat.load_error = 1'b1;
						d.mst = hcl_pkg::M_STOP;
						d.ph = '0;
					end
				end
				if (mtick && q.ph == 2'h3) begin
					d.mbit = q.mbit + 1'b1;
					if (q.mbit == hcl_pkg::BIT_ACK) begin
						d.mbit = '0;
						if (q.mst == hcl_pkg::M_RBYTE) begin
							// Image bytes arrive in address order.
							d.mem[q.maddr] = q.mbyte;
							d.maddr = q.maddr + 1'b1;
							if (q.maddr == hcl_pkg::EE_LAST) begin
								d.mst = hcl_pkg::M_STOP;
							end
						end else if (q.mseq == 2'h0) begin
							d.mseq = 2'h1;
							d.mbyte = hcl_pkg::EE_FIRST;
						end else if (q.mseq == 2'h1) begin
							d.mseq = 2'h2;
							d.mst = hcl_pkg::M_START;
						end else begin
							// One continuous sequential read to the end of the image.
							d.mseq = 2'h3;
							d.mst = hcl_pkg::M_RBYTE;
							d.maddr = hcl_pkg::EE_FIRST;
						end
					end
				end
			end
			hcl_pkg::M_STOP: begin
				// Clock low, data low, clock high, data released: STOP.
				d.scl_oe = (q.ph <= 2'h1);
				if (q.ph == 2'h1) begin
					d.sda_oe = 1'b1;
				end else if (q.ph == 2'h3) begin
					d.sda_oe = 1'b0;
				end
				if (mtick && q.ph == 2'h3) begin
					d.mst = hcl_pkg::M_DONE;
				end
			end
			default: begin
				// Done or off: the master leaves both lines alone.
				d.scl_oe = 1'b0;
			end
		endcase

		// Slave clock-low timer, cleared whenever the clock is seen high.
		if (q.scl_s2) begin
			d.tmo = '0;
		end else if (q.tmo != TMO_W'(TIMEOUT_CYCLES)) begin
			d.tmo = q.tmo + 1'b1;
		end

		// SMBus slave. It never pulls the clock line, so it cannot stretch it.
		if (!smb_on) begin
			d.slv = hcl_pkg::S_IDLE;
		end else if (q.slv == hcl_pkg::S_COMMIT) begin
			// Staged block is copied one byte per cycle after a clean STOP.
			waddr = q.cptr + 8'(q.bidx);
			if (reg_defined(waddr) && (!q.stat.usb_attach || waddr == hcl_pkg::REG_STATUS)) begin
				d.mem[waddr] = q.wbuf[q.bidx[4:0]];
			end
			d.bidx = q.bidx + 1'b1;
			if (q.bidx + 1'b1 == q.bcnt) begin
				d.slv = hcl_pkg::S_IDLE;
			end
		end else if (q.slv != hcl_pkg::S_IDLE && q.tmo == TMO_W'(TIMEOUT_CYCLES)) begin
			d.slv = hcl_pkg::S_IDLE;
			d.sda_oe = 1'b0;
		end else if (stop_ev) begin
			d.sda_oe = 1'b0;
			// Only a complete block write is committed; all else is dropped.
			// The clock rise ahead of a STOP has already counted one bit of a new byte.
			if (q.slv == hcl_pkg::S_WDATA && q.bidx == q.bcnt && q.sbit == hcl_pkg::BIT_EDGE) begin
				d.slv = hcl_pkg::S_COMMIT;
				d.bidx = '0;
			end else begin
				d.slv = hcl_pkg::S_IDLE;
			end
		end else if (start_ev) begin
			// A START right after the acked command code is the read turnaround.
			d.rd_ok = (q.slv == hcl_pkg::S_CNT) && (q.sbit == hcl_pkg::BIT_EDGE);
			d.slv = hcl_pkg::S_ADDR;
			d.sbit = '0;
			d.stx = 1'b0;
			d.sack = 1'b0;
			d.sda_oe = 1'b0;
		end else if (q.rise_dly && q.slv != hcl_pkg::S_IDLE) begin
			if (q.sbit != hcl_pkg::BIT_ACK) begin
				d.sshift = rx;
				d.sbit = q.sbit + 1'b1;
				if (q.sbit == hcl_pkg::BIT_MSB && !q.stx) begin
					d.sack = 1'b1;
					case (q.slv)
						hcl_pkg::S_ADDR: begin
							if (rx[7:1] != hcl_pkg::SMB_ADDR || rx[7:1] == hcl_pkg::GCALL_ADDR) begin
								d.slv = hcl_pkg::S_IDLE;
								d.sack = 1'b0;
							end else if (!rx[0]) begin
								d.slv = hcl_pkg::S_CMD;
							end else if (q.rd_ok) begin
								d.slv = hcl_pkg::S_RDATA;
							end else begin
								d.slv = hcl_pkg::S_IDLE;
								d.sack = 1'b0;
							end
						end
						hcl_pkg::S_CMD: begin
							d.ptr = rx;
							d.cptr = rx;
							d.slv = hcl_pkg::S_CNT;
						end
						hcl_pkg::S_CNT: begin
							if (rx == hcl_pkg::ZERO_BYTE || rx > hcl_pkg::BLK_MAX) begin
								d.slv = hcl_pkg::S_IDLE;
								d.sack = 1'b0;
							end else begin
								d.bcnt = rx[5:0];
								d.bidx = '0;
								d.slv = hcl_pkg::S_WDATA;
							end
						end
						default: begin
							// Data phase of a write: surplus bytes void the block.
							if (q.bidx == q.bcnt) begin
								d.slv = hcl_pkg::S_IDLE;
								d.sack = 1'b0;
							end else begin
								d.wbuf[q.bidx[4:0]] = rx;
								d.bidx = q.bidx + 1'b1;
							end
						end
					endcase
				end
			end else begin
				// Acknowledge clock.
				d.sbit = '0;
				d.sack = 1'b0;
				if (q.slv == hcl_pkg::S_RDATA && !q.stx) begin
					d.stx = 1'b1;
					d.txb = hcl_pkg::BLK_MAX;
				end else if (q.stx && q.bit_s2) begin
					d.slv = hcl_pkg::S_IDLE;
				end else if (q.stx) begin
					// Undefined registers read back as zero.
					d.txb = reg_defined(q.ptr) ? q.mem[q.ptr] : hcl_pkg::ZERO_BYTE;
					d.ptr = q.ptr + 1'b1;
				end
			end
		end else if (scl_fall && q.slv != hcl_pkg::S_IDLE) begin
			// Data is only ever changed while the clock is low.
			if (q.sbit == hcl_pkg::BIT_ACK) begin
				d.sda_oe = !q.stx && q.sack;
			end else if (q.stx) begin
				d.sda_oe = !bit_of(q.txb, q.sbit);
			end else begin
				d.sda_oe = 1'b0;
			end
		end

		// Attach and hub-side effects.
		if (!q.stat.cfg_done) begin
			if (q.src == hcl_pkg::SRC_DEFAULT && oper) begin
				d.stat.cfg_done = 1'b1;
			end else if (q.mst == hcl_pkg::M_DONE) begin
				d.stat.cfg_done = 1'b1;
			end else if (smb_on && q.mem[hcl_pkg::REG_STATUS][hcl_pkg::ATTACH_BIT]) begin
				d.stat.cfg_done = 1'b1;
			end
		end
		d.stat.usb_attach = q.stat.cfg_done;
		d.stat.led_enable = q.stat.cfg_done;
		d.pwr = q.stat.cfg_done ? hcl_pkg::PORT_ALL_ON : '0;
		// Strap polarity only counts in the default configuration.
		if (oper && q.src != hcl_pkg::SRC_DEFAULT) begin
			d.stat.led_amber_act_low = 1'b0;
			d.stat.led_green_act_low = 1'b0;
		end
		d.scl_o = 1'b0;
		d.sda_o = 1'b0;
	end

	// State register. Reset clears everything: pins released, ports unpowered.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state flip-flops.
	assign scl_out = q.scl_o;
	assign scl_oe = q.scl_oe;
	assign sda_out = q.sda_o;
	assign sda_oe = q.sda_oe;
	assign port_power_enable = q.pwr;
	assign status = q.stat;
endmodule : hcl_loader

// File: hcl_loader_monitor.sv
module hcl_loader_monitor #(
	parameter int OPWAIT_CYCLES = hcl_pkg::OPWAIT_CYC,
	parameter int TIMEOUT_CYCLES = hcl_pkg::TMO_CYC
) (
	// Core clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Source select.
	input wire logic config_source_select_hi,
	input wire logic config_source_select_lo,
	// Serial pins.
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Results.
	input wire logic [6:0] port_power_enable,
	input wire hcl_pkg::hcl_stat_t status
);
	int since_q; // Cycles since reset release, saturating.
	int low_q; // Length of the present clock-low spell on the wire.
	int hold_q; // Length of the present master pull on the clock.
	logic smb; // Slave mode selected.
	assign smb = config_source_select_hi && !config_source_select_lo;
	// Counters for the timed rules; int is two-state, so they never start unknown.
	always_ff @(posedge clk) begin
		since_q <= !rst_n ? 0 : (since_q < 32'h0010_0000 ? since_q + 1 : since_q);
		low_q <= scl_in ? 0 : low_q + 1;
		hold_q <= scl_oe ? hold_q + 1 : 0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Configuration finishes first, attach and port power follow one cycle later.
	sequence done_rise;
		$rose(status.cfg_done);
	endsequence
	sequence attach_on;
		status.usb_attach && port_power_enable == 7'h7F;
	endsequence
	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n |=> !scl_oe && !sda_oe && status == '0 && port_power_enable == '0) else $error("outputs active in reset");
	wait_quiet_a: assert property (since_q < OPWAIT_CYCLES |-> !scl_oe && !sda_oe)
		else $error("bus touched before operational");
	ee_kickoff_a: assert property (since_q == OPWAIT_CYCLES && config_source_select_lo |-> ##[1:6] scl_oe)
		else $error("configuration read did not start");
	ee_bit_time_a: assert property ($fell(scl_oe) |-> hold_q == 2 * hcl_pkg::QTR_CYC)
		else $error("clock low time off the standard rate");
	no_stretch_a: assert property (smb |-> !scl_oe)
		else $error("slave pulled the clock");
	smb_edge_a: assert property (smb && $changed(sda_oe) |-> !scl_in)
		else $error("slave data moved with clock high");
	timeout_free_a: assert property (smb && low_q > TIMEOUT_CYCLES + 10 |-> !sda_oe)
		else $error("data held after clock-low timeout");
	power_attach_a: assert property (port_power_enable != '0 |-> attach_on)
		else $error("port power without attach");
	done_attach_a: assert property (done_rise |=> attach_on)
		else $error("attach did not follow completion");
endmodule : hcl_loader_monitor

bind hcl_loader hcl_loader_monitor #(.OPWAIT_CYCLES(OPWAIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
	.clk(clk), .rst_n(rst_n), .config_source_select_hi(config_source_select_hi),
	.config_source_select_lo(config_source_select_lo), .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.port_power_enable(port_power_enable), .status(status));

// File: hcl_eeprom_model.sv
module hcl_eeprom_model (
	// Keeps the model off the wire outside the memory mode.
	input wire logic en,
	// Resolved bus wires.
	input wire logic scl,
	input wire logic sda,
	// Data pull and the last three bytes received.
	output logic sda_oe,
	output logic [23:0] seen
);
	logic [7:0] sh; // Byte being shifted in.
	int n; // Bit position within the byte.
	logic first; // The byte is the address byte.
	logic rd; // A read address was accepted.
	initial begin
		sda_oe = 1'b0;
		seen = '0;
		n = 0;
		first = 1'b0;
		rd = 1'b0;
	end
	// Data falling with the clock high is a START; framing restarts.
	always @(negedge sda) begin
		if (en && scl) begin
			n = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	// Bits are taken on the rising clock, most significant first.
	always @(posedge scl) begin
		if (en && n < 8) begin
			sh = {sh[6:0], sda};
		end
		n = n + 1;
	end
	// Acknowledge its own address and every later written byte; read data is not modelled, so the pull-up shows.
	always @(negedge scl) begin
		if (en && n == 8) begin
			seen = {seen[15:0], sh};
			sda_oe = !rd && (!first || sh[7:1] == 7'h50);
		end else if (n == 9) begin
			sda_oe = 1'b0;
			rd = first && sh[0];
			first = 1'b0;
			n = 0;
		end
	end
endmodule : hcl_eeprom_model

// File: hcl_loader_tb.sv
module hcl_loader_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OPW = 16; // Shortened start-up wait.
	localparam int TMO = 2000; // Shortened clock-low timeout.
	// One block write and the two-byte read-back it should leave.
	typedef struct packed {
		logic [6:0] a;
		logic [7:0] cmd, cnt;
		logic [2:0] n;
		logic [31:0] dv;
		logic [7:0] ak, rcmd;
		logic [15:0] rd;
	} hcl_row_t;
	logic clk, lclk, rst_n, sel_hi, sel_lo, amber, green, s;
	logic h_scl, h_sda; // Host pulls on the wires.
	logic scl_out, scl_oe, sda_out, sda_oe, m_sda, scl_w, sda_w;
	logic [6:0] pwr;
	logic [23:0] seen;
	hcl_pkg::hcl_stat_t stat;
	int fail_count, cmp_count;
	hcl_row_t rows [7];
	logic [7:0] ak, r;
	logic [31:0] got;
	// Pulled-up open-drain wires.
	assign scl_w = !(scl_oe || h_scl);
	assign sda_w = !(sda_oe || h_sda || m_sda);
	hcl_loader #(.OPWAIT_CYCLES(OPW), .TIMEOUT_CYCLES(TMO)) u_hcl_loader (.clk(clk), .rst_n(rst_n),
		.scl_link_clk(scl_w), .config_source_select_hi(sel_hi), .config_source_select_lo(sel_lo),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .led_amber_in(amber), .led_green_in(green), .port_power_enable(pwr), .status(stat));
	hcl_eeprom_model u_hcl_eeprom_model (.en(sel_lo), .scl(scl_w), .sda(sda_w), .sda_oe(m_sda), .seen(seen));
	// Core clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	// Host link clock, phase unrelated to the core clock.
	initial begin
		lclk = 1'b0;
		#2.7;
		forever #6 lclk = !lclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen_v);
		cmp_count++;
		if (seen_v !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen_v);
		end
	endtask : chk
	task automatic hw(input int n);
		repeat (n) @(posedge lclk);
	endtask : hw
	// START or repeated START; leaves the clock pulled low.
	task automatic start_c();
		h_sda = 1'b0;
		hw(8);
		h_scl = 1'b0;
		hw(8);
		h_sda = 1'b1;
		hw(8);
		h_scl = 1'b1;
		hw(8);
	endtask : start_c
	task automatic stop_c();
		h_sda = 1'b1;
		hw(8);
		h_scl = 1'b0;
		hw(8);
		h_sda = 1'b0;
		hw(8);
	endtask : stop_c
	// Data is set while the clock is low and sampled at the end of the high time.
	task automatic sbit(input logic b, output logic q);
		h_sda = !b;
		hw(8);
		h_scl = 1'b0;
		hw(8);
		q = sda_w;
		h_scl = 1'b1;
	endtask : sbit
	task automatic sbyte(input logic [7:0] d, input logic hb, output logic [7:0] q, output logic a);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			sbit(d[i], q[i]);
		end
		sbit(hb, t);
		a = !t;
	endtask : sbyte
	// Sends every byte even when refused, so an idle slave must stay silent.
	task automatic blk_wr(input hcl_row_t w, output logic [7:0] a);
		logic [7:0] q;
		a = '0;
		start_c();
		sbyte({w.a, 1'b0}, 1'b1, q, a[7]);
		sbyte(w.cmd, 1'b1, q, a[6]);
		sbyte(w.cnt, 1'b1, q, a[5]);
		for (int i = 0; i < w.n; i++) begin
			sbyte(w.dv[31 - 8 * i -: 8], 1'b1, q, a[4 - i]);
		end
		stop_c();
		hw(60);
	endtask : blk_wr
	// Result: three acks, count byte, two data bytes.
	task automatic blk_rd(input logic [7:0] cmd, output logic [31:0] v);
		logic [7:0] q;
		v = '0;
		start_c();
		sbyte(8'h58, 1'b1, q, v[26]);
		sbyte(cmd, 1'b1, q, v[25]);
		start_c();
		sbyte(8'h59, 1'b1, q, v[24]);
		sbyte(8'hFF, 1'b0, v[23:16], q[0]);
		sbyte(8'hFF, 1'b0, v[15:8], q[0]);
		sbyte(8'hFF, 1'b1, v[7:0], q[0]);
		stop_c();
		hw(20);
	endtask : blk_rd
	// Straps and select are held from reset until well past their capture.
	task automatic restart(input logic [1:0] sel, input logic [1:0] st);
		@(negedge clk);
		rst_n = 1'b0;
		{sel_hi, sel_lo} = sel;
		{amber, green} = st;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (OPW + 8) @(negedge clk);
	endtask : restart
	task automatic end_of_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	// Watchdog: the run needs about 53,000 cycles, so this leaves ample margin.
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		{rst_n, sel_hi, sel_lo, amber, green, h_scl, h_sda} = '0;
		fail_count = 0;
		cmp_count = 0;
		rows[0] = '{7'h2C, 8'h10, 8'h02, 3'h2, 32'hA55A_0000, 8'hF8, 8'h10, 16'hA55A};
		rows[1] = '{7'h2D, 8'h10, 8'h02, 3'h2, 32'h1122_0000, 8'h00, 8'h10, 16'hA55A};
		rows[2] = '{7'h00, 8'h10, 8'h02, 3'h2, 32'h1122_0000, 8'h00, 8'h10, 16'hA55A};
		rows[3] = '{7'h2C, 8'h10, 8'h00, 3'h0, 32'h0000_0000, 8'hC0, 8'h10, 16'hA55A};
		rows[4] = '{7'h2C, 8'h10, 8'h21, 3'h0, 32'h0000_0000, 8'hC0, 8'h10, 16'hA55A};
		rows[5] = '{7'h2C, 8'h10, 8'h02, 3'h1, 32'h7700_0000, 8'hF0, 8'h10, 16'hA55A};
		rows[6] = '{7'h2C, 8'h3E, 8'h03, 3'h3, 32'hC33C_9900, 8'hFC, 8'h3F, 16'h3C00};
		// Strap combinations in default mode set the lamp polarity.
		for (int i = 0; i < 4; i++) begin
			restart(2'h0, i[1:0]);
			chk("led polarity", {30'h0, i[1:0]}, {30'h0, stat.led_amber_act_low, stat.led_green_act_low});
		end
		// Memory mode: dummy write of word address, then read address, after opening.
		restart(2'h1, 2'h0);
		repeat (31000) @(negedge clk);
		chk("memory opening bytes", 32'h00A0_00A1, {8'h00, seen});
		chk("open drain levels", 32'h0, {29'h0, scl_out, sda_out, stat.load_error});
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk("pins in reset", 32'h0, {29'h0, scl_oe, sda_oe, |pwr});
		restart(2'h2, 2'h0);
		foreach (rows[i]) begin
			blk_wr(rows[i], ak);
			chk("write acks", {24'h0, rows[i].ak}, {24'h0, ak});
			blk_rd(rows[i].rcmd, got);
			chk("read back", {8'h07, 8'h20, rows[i].rd}, got);
		end
		// A START then STOP in mid-transfer must leave the slave idle and ready.
		start_c();
		sbyte(8'h58, 1'b1, r, s);
		start_c();
		stop_c();
		blk_wr(rows[0], ak);
		chk("write after start-stop", {24'h0, rows[0].ak}, {24'h0, ak});
		// Clock held low during the acknowledge until the slave gives up.
		r = 8'h58;
		start_c();
		for (int i = 7; i >= 0; i--) begin
			sbit(r[i], s);
		end
		repeat (20) @(negedge clk);
		chk("ack before timeout", 32'h1, {31'h0, sda_oe});
		repeat (TMO + 40) @(negedge clk);
		chk("ack after timeout", 32'h0, {31'h0, sda_oe});
		stop_c();
		blk_wr(rows[0], ak);
		chk("write after timeout", {24'h0, rows[0].ak}, {24'h0, ak});
		chk("no attach yet", 32'h0, {31'h0, stat.usb_attach});
		blk_wr('{7'h2C, 8'hFF, 8'h01, 3'h1, 32'h0100_0000, 8'h00, 8'h00, 16'h0000}, ak);
		repeat (10) @(negedge clk);
		chk("attach and power", 32'h3FF, {22'h0, stat.led_enable, stat.usb_attach, stat.cfg_done, pwr});
		blk_wr('{7'h2C, 8'h10, 8'h01, 3'h1, 32'h3300_0000, 8'h00, 8'h00, 16'h0000}, ak);
		blk_rd(8'h10, got);
		chk("write protect", 32'hA55A, {16'h0, got[15:0]});
		end_of_test();
	end
endmodule : hcl_loader_tb
